//--- hdl/rcc_pkg.sv
/*
 * Package of the reset cause controller: register map, field layout,
 * reset values and reset stretch timing.
 * Assumes a 32-bit APB bus and a 125 MHz pclk.
 */
`default_nettype none

package rcc_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CAUSE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] CFG_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] STATE_OFS = 8'h14;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int CAUSE_W = 8;
  localparam int CFG_W = 8;
  localparam int CLK_SEL_W = 2;
  localparam int CTRL_SWR = 0;
  localparam int CTRL_REG_EN = 1;
  localparam int CTRL_CLK_LO = 2;
  localparam int CTRL_INJECT = 4;
  localparam int STATE_SLEEP = 0;
  localparam int STATE_ARMED = 1;
  localparam int STATE_MISMATCH = 2;
  localparam int STATE_SYS_RST = 3;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
  localparam logic [CLK_SEL_W-1:0] CLK_SEL_RST = 2'h0;
  localparam logic REG_EN_RST = 1'b1;
  localparam logic [CAUSE_W-1:0] MASK_RST = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_HOLD_NS = 64;
  localparam int RST_HOLD_CYC =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 4;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic ill_op;
    logic trap;
    logic sw_rst;
    logic cfg_mis;
    logic brown_out;
    logic wdog;
    logic pwr_on;
    logic mstr_clr;
  } rcc_cause_t;

  typedef struct packed {
    logic hard_trap;
    logic soft_trap;
    logic reset_instr;
    logic illegal_opcode;
  } rcc_core_ev_t;

endpackage : rcc_pkg

`default_nettype wire

//--- hdl/rcc_rst_sync.sv
/*
 * Reset stretcher: asserts its reset output at once on an async low
 * input, holds it on a sync request, releases it synchronously.
 * Assumes clk runs during and after the asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module rcc_rst_sync
  import rcc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req,
  output var logic rst_n
);

  logic [1:0] meta_r;
  logic [RST_CNT_W-1:0] hold_r;

  // ************************************************************
  // Release synchroniser
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      meta_r <= 2'h0;
    else
      meta_r <= {meta_r[0], 1'b1};
  end

  // ************************************************************
  // Hold counter, reloaded on every request
  // ************************************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      hold_r <= RST_CNT_W'(RST_HOLD_CYC);
    else if (!meta_r[1] || req)
      hold_r <= RST_CNT_W'(RST_HOLD_CYC);
    else if (hold_r != '0)
      hold_r <= hold_r - 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_n <= 1'b0;
    else
      rst_n <= meta_r[1] && !req && (hold_r == '0);
  end

endmodule : rcc_rst_sync

`default_nettype wire

//--- hdl/rcc_top.sv
/*
 * Reset cause controller: gathers reset sources, drives the system
 * reset, keeps sticky cause flags and an APB register file.
 * Assumes presetn is the power-domain reset, which the system reset
 * it produces does not touch; pins are asynchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module rcc_top
  import rcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output var logic [DATA_W-1:0] prdata,
  output var logic pready,
  output var logic pslverr,
  input wire logic master_clear_pin_n,
  input wire logic supply_ok,
  input wire logic regulator_low,
  input wire logic watchdog_timeout,
  input wire logic cpu_sleep,
  input wire rcc_core_ev_t core_ev,
  output var logic sys_rst_n,
  output var logic [CLK_SEL_W-1:0] clk_sel,
  output var logic regulator_en,
  output var logic wake,
  output var logic irq
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic master_clear_pin_low;
  logic supply_hi;
  logic reg_low;
  logic wdog_to;
  logic pwr_prev_r;
  logic pwr_armed_r;
  logic pwr_pulse;
  logic wdog_prev_r;
  logic wdog_edge;
  logic wake_nxt;
  rcc_cause_t ev;
  rcc_cause_t cause_r;
  rcc_cause_t int_stat_r;
  logic [CAUSE_W-1:0] int_mask_r;
  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_shadow_r;
  logic cfg_mismatch;
  logic sw_req_r;
  logic reg_en_r;
  logic [CLK_SEL_W-1:0] clk_sel_r;
  logic sys_req;
  logic sys_arst_n;
  logic wr_en;
  logic rd_en;
  logic setup;
  logic [DATA_W-1:0] rd_nxt;
  logic hit;
  logic irq_nxt;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [DATA_W-1:0] zext8(
    input logic [7:0] v
  );
    zext8 = {{(DATA_W-8){1'b0}}, v};
  endfunction : zext8

  function automatic logic is_reg(
    input logic [ADDR_W-1:0] a
  );
    is_reg = (a == CAUSE_OFS) || (a == INT_STAT_OFS) ||
             (a == INT_MASK_OFS) || (a == CTRL_OFS) ||
             (a == CFG_OFS) || (a == STATE_OFS);
  endfunction : is_reg

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end
    else
    begin
      pin_s1_r <= {watchdog_timeout, regulator_low, supply_ok,
                   ~master_clear_pin_n};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign master_clear_pin_low = pin_s2_r[0];
  assign supply_hi = pin_s2_r[1];
  assign reg_low = pin_s2_r[2];
  assign wdog_to = pin_s2_r[3];

  // ************************************************************
  // Power-on detector
  // ************************************************************
  // Armed from presetn so the first rise after power-up counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwr_prev_r <= 1'b0;
      pwr_armed_r <= 1'b1;
    end
    else
    begin
      pwr_prev_r <= supply_hi;
      if (pwr_pulse)
        pwr_armed_r <= 1'b0;
      else if (!supply_hi)
        pwr_armed_r <= 1'b1;
    end
  end

  assign pwr_pulse = supply_hi && !pwr_prev_r && pwr_armed_r;

  // ************************************************************
  // Watchdog: reset when running, wake when asleep
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdog_prev_r <= 1'b0;
    else
      wdog_prev_r <= wdog_to;
  end

  assign wdog_edge = wdog_to && !wdog_prev_r;
  assign wake_nxt = wdog_edge && cpu_sleep;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake <= 1'b0;
    else
      wake <= wake_nxt;
  end

  // ************************************************************
  // Configuration store with complementary shadow
  // ************************************************************
  // Shadow sits in the power domain so a mismatch survives resets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r <= CFG_RST;
      cfg_shadow_r <= ~CFG_RST;
    end
    else if (wr_en && paddr == CFG_OFS)
    begin
      cfg_r <= pwdata[CFG_W-1:0];
      cfg_shadow_r <= ~pwdata[CFG_W-1:0];
    end
    else if (wr_en && paddr == CTRL_OFS && pwdata[CTRL_INJECT])
      cfg_shadow_r <= cfg_shadow_r ^ {{(CFG_W-1){1'b0}}, 1'b1};
  end

  // No sleep gating: checked every cycle
  assign cfg_mismatch = (cfg_r ^ cfg_shadow_r) != '1;

  // ************************************************************
  // Reset cause events
  // ************************************************************
  always_comb
  begin
    ev = '0;
    ev.mstr_clr = master_clear_pin_low;
    ev.pwr_on = pwr_pulse;
    ev.wdog = wdog_edge && !cpu_sleep;
    ev.brown_out = reg_low && reg_en_r;
    ev.cfg_mis = cfg_mismatch;
    ev.sw_rst = sw_req_r || core_ev.reset_instr;
    ev.trap = core_ev.hard_trap && core_ev.soft_trap;
    ev.ill_op = core_ev.illegal_opcode;
  end

  // ************************************************************
  // System reset generation
  // ************************************************************
  // Pin and running watchdog bypass the clock; sleep gate is async too
  assign sys_arst_n = presetn && master_clear_pin_n &&
                      !(watchdog_timeout && !cpu_sleep);
  assign sys_req = |ev;

  rcc_rst_sync u_rst_sync (
    .clk(pclk),
    .arst_n(sys_arst_n),
    .req(sys_req),
    .rst_n(sys_rst_n)
  );

  // ************************************************************
  // Control register
  // ************************************************************
  // Software reset bit self-clears after one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sw_req_r <= 1'b0;
    else
      sw_req_r <= wr_en && paddr == CTRL_OFS && pwdata[CTRL_SWR];
  end

  // Clock choice is reset only by power-on, not by system reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clk_sel_r <= CLK_SEL_RST;
    else if (pwr_pulse)
      clk_sel_r <= CLK_SEL_RST;
    else if (wr_en && paddr == CTRL_OFS)
      clk_sel_r <= pwdata[CTRL_CLK_LO +: CLK_SEL_W];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reg_en_r <= REG_EN_RST;
    else if (wr_en && paddr == CTRL_OFS)
      reg_en_r <= pwdata[CTRL_REG_EN];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_sel <= CLK_SEL_RST;
      regulator_en <= REG_EN_RST;
    end
    else
    begin
      clk_sel <= clk_sel_r;
      regulator_en <= reg_en_r;
    end
  end

  // ************************************************************
  // Cause flags
  // ************************************************************
  // Power domain only; a set in the clear cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cause_r <= '0;
    else if (wr_en && paddr == CAUSE_OFS)
      cause_r <= (cause_r & ~pwdata[CAUSE_W-1:0]) | ev;
    else
      cause_r <= cause_r | ev;
  end

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_stat_r <= '0;
    else if (rd_en && paddr == INT_STAT_OFS)
      int_stat_r <= ev;
    else
      int_stat_r <= int_stat_r | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_mask_r <= MASK_RST;
    else if (wr_en && paddr == INT_MASK_OFS)
      int_mask_r <= pwdata[CAUSE_W-1:0];
  end

  assign irq_nxt = |(int_stat_r & int_mask_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= irq_nxt;
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  // Data is captured in setup so the access phase needs no wait
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite && hit;
  assign rd_en = psel && penable && pready && !pwrite && hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hit <= 1'b0;
    else if (setup)
      hit <= is_reg(paddr);
  end

  always_comb
  begin
    rd_nxt = '0;
    case (paddr)
      CAUSE_OFS:
        rd_nxt = zext8(cause_r);
      INT_STAT_OFS:
        rd_nxt = zext8(int_stat_r);
      INT_MASK_OFS:
        rd_nxt = zext8(int_mask_r);
      CTRL_OFS:
        rd_nxt = zext8({3'h0, 1'b0, clk_sel_r, reg_en_r, 1'b0});
      CFG_OFS:
        rd_nxt = zext8(cfg_r);
      STATE_OFS:
        rd_nxt = zext8({4'h0, !sys_rst_n, cfg_mismatch, pwr_armed_r,
                        cpu_sleep});
      default:
        rd_nxt = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !is_reg(paddr);
      if (setup && !pwrite)
        prdata <= rd_nxt;
      else if (setup)
        prdata <= '0;
    end
  end

endmodule : rcc_top

`default_nettype wire

//--- tb/rcc_top_properties.sv
/*
 * Port timing checker of the reset cause controller.
 * Assumes it is bound to rcc_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Checker
// ************************************************************
module rcc_chk
  import rcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic master_clear_pin_n,
  input wire logic watchdog_timeout,
  input wire logic cpu_sleep,
  input wire rcc_core_ev_t core_ev,
  input wire logic sys_rst_n,
  input wire logic [CLK_SEL_W-1:0] clk_sel,
  input wire logic wake
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_trap_pair;
    core_ev.hard_trap && core_ev.soft_trap;
  endsequence

  a_pready_next: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_pready_one: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_pin_async: assert property (!master_clear_pin_n |-> !sys_rst_n)
    else $error("pin low without system reset");
  // Guarded by psel so a legal write may still move the clock choice
  a_pin_keeps_clk: assert property (
    !master_clear_pin_n && !psel |=> $stable(clk_sel))
    else $error("clock choice moved in pin reset");
  // Awake watchdog must pull reset down without waiting for the sync
  a_wdog_async: assert property (
    watchdog_timeout && !cpu_sleep |-> !sys_rst_n)
    else $error("awake watchdog without system reset");
  a_sleep_wake: assert property (
    $rose(watchdog_timeout) && cpu_sleep |-> ##[1:6] wake)
    else $error("no wake for timeout in sleep");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  a_trap_reset: assert property (s_trap_pair |=> !sys_rst_n)
    else $error("trap pair without reset");
  a_illop_reset: assert property (
    core_ev.illegal_opcode |=> !sys_rst_n)
    else $error("illegal opcode without reset");
  a_rst_hold: assert property ($fell(sys_rst_n) |-> !sys_rst_n [*8])
    else $error("system reset shorter than hold");
endmodule : rcc_chk

bind rcc_top rcc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .master_clear_pin_n(master_clear_pin_n),
  .watchdog_timeout(watchdog_timeout), .cpu_sleep(cpu_sleep),
  .core_ev(core_ev), .sys_rst_n(sys_rst_n), .clk_sel(clk_sel), .wake(wake));

`default_nettype wire

//--- tb/rcc_src_model.sv
/*
 * Model of the reset sources: pins, supply, watchdog and core events.
 * Assumes the bench calls its tasks; all changes follow a clk edge.
 */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Reset source model
// ************************************************************
module rcc_src_model
  import rcc_pkg::*;
(
  input wire logic clk,
  output var logic master_clear_pin_n,
  output var logic supply_ok,
  output var logic regulator_low,
  output var logic watchdog_timeout,
  output var logic cpu_sleep,
  output var rcc_core_ev_t core_ev
);
  initial
  begin
    master_clear_pin_n = 1'b1;
    supply_ok = 1'b0;
    regulator_low = 1'b0;
    watchdog_timeout = 1'b0;
    cpu_sleep = 1'b0;
    core_ev = '0;
  end

  // Levels are held whole cycles so the two-flop sync sees them
  task automatic set(input int k, input logic v);
    @(posedge clk);
    case (k)
      0: master_clear_pin_n <= !v;
      1: supply_ok <= v;
      2: watchdog_timeout <= v;
      3: regulator_low <= v;
      default: cpu_sleep <= v;
    endcase
  endtask : set

  task automatic pulse(input int k, input int n);
    set(k, 1'b1);
    repeat (n) @(posedge clk);
    set(k, 1'b0);
  endtask : pulse

  task automatic core(input rcc_core_ev_t e);
    @(posedge clk);
    core_ev <= e;
    @(posedge clk);
    core_ev <= '0;
  endtask : core
endmodule : rcc_src_model

`default_nettype wire

//--- tb/reset_cause_controller_tb.sv
/*
 * Self-checking bench of rcc_top over APB with a reset source model.
 * Assumes the zero-wait APB slave and the cause layout of the package.
 */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Bench
// ************************************************************
module reset_cause_controller_tb
  import rcc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, pin_n, sup, reg_low, wdog, sleep, rst_n;
  logic reg_en, wake, irq;
  logic saw_wake = 1'b0;
  logic [CLK_SEL_W-1:0] clk_sel;
  logic [7:0] acc = '0;
  rcc_core_ev_t core_ev;
  int fails = 0;
  int checked = 0;
  int cyc = 0;

  rcc_src_model src (.clk(pclk), .master_clear_pin_n(pin_n),
    .supply_ok(sup), .regulator_low(reg_low), .watchdog_timeout(wdog),
    .cpu_sleep(sleep), .core_ev(core_ev));

  rcc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_clear_pin_n(pin_n), .supply_ok(sup), .regulator_low(reg_low),
    .watchdog_timeout(wdog), .cpu_sleep(sleep), .core_ev(core_ev),
    .sys_rst_n(rst_n), .clk_sel(clk_sel), .regulator_en(reg_en),
    .wake(wake), .irq(irq));

  always #4 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cyc++;
    if (wake === 1'b1)
      saw_wake <= 1'b1;
    // Whole run is a few hundred cycles
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      $display("FAIL %s expected %h seen %h", n, x, s);
      fails++;
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a,
                    input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, '0, r, e);
    chk(n, r, x);
    chk("pslverr", {31'h0, e}, {31'h0, xe});
  endtask : rd

  // Waits for the system reset to end, bounded by the global timeout
  task automatic run();
    do
      @(posedge pclk);
    while (rst_n !== 1'b1);
    repeat (2) @(posedge pclk);
  endtask : run

  task automatic fire(input int k);
    case (k)
      4:
      begin
        wr(CTRL_OFS, 32'h0000_001e);
        wr(CFG_OFS, 32'h0000_005a);
      end
      5: wr(CTRL_OFS, 32'h0000_000f);
      6: src.core(4'hc);
      7: src.core(4'h1);
      default: src.pulse(k, 3);
    endcase
    repeat (2) @(posedge pclk);
    #1;
  endtask : fire

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    src.set(1, 1'b1);
    run();
    rd("cause", CAUSE_OFS, 32'h0000_0002, 1'b0);
    wr(CAUSE_OFS, 32'h0000_0002);
    rd("cause", CAUSE_OFS, '0, 1'b0);
    rd("ctrl", CTRL_OFS, 32'h0000_0002, 1'b0);
    rd("mask", INT_MASK_OFS, '0, 1'b0);
    rd("unmapped", 8'h20, '0, 1'b1);
    rd("stat", INT_STAT_OFS, 32'h0000_0002, 1'b0);
    wr(CTRL_OFS, 32'h0000_000e);
    wr(INT_MASK_OFS, 32'h0000_0080);
    foreach (acc[k])
      if (k != 1)
      begin
        acc[k] = 1'b1;
        fire(k);
        chk("sys_rst_n", {31'h0, rst_n}, '0);
        run();
        rd("cause", CAUSE_OFS, {24'h0, acc}, 1'b0);
        chk("clk_sel", {30'h0, clk_sel}, 32'h0000_0003);
        chk("irq", {31'h0, irq}, {31'h0, acc[7]});
      end
    rd("stat", INT_STAT_OFS, {24'h0, acc}, 1'b0);
    rd("cfg", CFG_OFS, 32'h0000_005a, 1'b0);
    rd("stat", INT_STAT_OFS, '0, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, irq}, '0);
    wr(CAUSE_OFS, 32'h0000_0001);
    rd("cause", CAUSE_OFS, 32'h0000_00fc, 1'b0);
    wr(CAUSE_OFS, 32'h0000_00fc);
    rd("cause", CAUSE_OFS, '0, 1'b0);
    src.core(4'h8);
    src.set(8, 1'b1);
    rd("state", STATE_OFS, 32'h0000_0001, 1'b0);
    src.pulse(2, 3);
    repeat (6) @(posedge pclk);
    src.set(8, 1'b0);
    wr(CTRL_OFS, 32'h0000_000c);
    src.pulse(3, 3);
    repeat (6) @(posedge pclk);
    chk("sys_rst_n", {31'h0, rst_n}, 32'h0000_0001);
    chk("wake", {31'h0, saw_wake}, 32'h0000_0001);
    chk("reg_en", {31'h0, reg_en}, '0);
    rd("cause", CAUSE_OFS, '0, 1'b0);
    src.set(1, 1'b0);
    repeat (4) @(posedge pclk);
    src.set(1, 1'b1);
    run();
    rd("cause", CAUSE_OFS, 32'h0000_0002, 1'b0);
    chk("clk_sel", {30'h0, clk_sel}, '0);
    conclude();
  end
endmodule : reset_cause_controller_tb

`default_nettype wire
